// File: hw/btsk_exec.sv
// execution sequencer for the bit-test-and-skip instructions
`timescale 1ns/1ps
`default_nettype none
`include "btsk_cfg.svh"

// What this block does
// RULE1: skip-if-set skips the next instruction when the tested bit reads one
// RULE2: a taken skip discards the instruction word fetched during the test
// RULE3: a no-operation cycle replaces the discarded word, two cycles total
// RULE4: access flag zero addresses the quick-access bank, ignoring the bank
// RULE5: access flag one takes the bank from the bank select register
// RULE6: extended set, access zero, address up to 5Fh uses indexed offset
// RULE7: decode 4-bit opcode, 3-bit bit index, access flag, 8-bit address
module btsk_exec
    import btsk_pkg::*;
(
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_reset,
    input  wire logic [`BTSK_INSTR_W-1:0] i_instr,
    input  wire logic [3:0]               i_bank_select,
    input  wire logic                     i_ext_set_en,
    input  wire logic [`BTSK_ADDR_W-1:0]  i_index_base,
    input  wire logic [7:0]               i_rd_data,
    output logic                          o_cycle_start,
    output logic                          o_rd_en,
    output logic [`BTSK_ADDR_W-1:0]       o_rd_addr,
    output logic                          o_indexed,
    output logic                          o_bit_test,
    output logic                          o_skip_taken,
    output logic                          o_discard
);
    btsk_phase_e              phase_reg;
    btsk_phase_e              phase_next;
    logic [`BTSK_INSTR_W-1:0] instr_reg;
    logic                     nop_reg;
    logic                     bit_val_reg;
    btsk_op_e                 op;
    logic [2:0]               bit_idx;
    logic                     skip_cond;

    btsk_addr_if addr_bus ();

    btsk_addr_gen u_addr_gen (
        .a (addr_bus)
    );

    // quarter-cycle sequencer
    always_comb begin
        case (phase_reg)
            BTSK_Q1: phase_next = BTSK_Q2;
            BTSK_Q2: phase_next = BTSK_Q3;
            BTSK_Q3: phase_next = BTSK_Q4;
            BTSK_Q4: phase_next = BTSK_Q1;
            default: phase_next = BTSK_Q1;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            phase_reg <= BTSK_Q4;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_cycle_start <= 1'b0;
        end else begin
            o_cycle_start <= (phase_next == BTSK_Q1);
        end
    end

    // opcode decode of the current word
    always_comb begin
        bit_idx = instr_reg[`BTSK_BIT_HI:`BTSK_BIT_LO];              // [RULE7]
        case (instr_reg[`BTSK_OPC_HI:`BTSK_OPC_LO])
            `BTSK_OPC_SKIP_CLR: op = BTSK_OP_SKIP_CLEAR;              // [RULE7]
            `BTSK_OPC_SKIP_SET: op = BTSK_OP_SKIP_SET;                // [RULE7]
            default:            op = BTSK_OP_OTHER;
        endcase
    end

    assign addr_bus.f_addr     = instr_reg[`BTSK_F_HI:`BTSK_F_LO];
    assign addr_bus.access     = instr_reg[`BTSK_ACCESS_POS];
    assign addr_bus.bank       = i_bank_select;
    assign addr_bus.ext_en     = i_ext_set_en;
    assign addr_bus.index_base = i_index_base;

    // instruction register: next word loaded at the end of Q4
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            instr_reg <= `BTSK_NOP_WORD;
        end else if (phase_reg == BTSK_Q4) begin
            instr_reg <= i_instr;
        end
    end

    // discard flag: fetched word is replaced by a no-operation
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            nop_reg <= 1'b0;
        end else if (phase_reg == BTSK_Q4) begin
            nop_reg <= o_skip_taken;                                  // [RULE2]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_discard <= 1'b0;
        end else if (phase_reg == BTSK_Q4) begin
            o_discard <= o_skip_taken;                                // [RULE3]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_bit_test <= 1'b0;
        end else if (phase_reg == BTSK_Q1) begin
            o_bit_test <= (op != BTSK_OP_OTHER) && !nop_reg;
        end
    end

    // Q1 decode: present operand address for the Q2 read
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rd_en   <= 1'b0;
            o_rd_addr <= '0;
            o_indexed <= 1'b0;
        end else if (phase_reg == BTSK_Q1) begin
            o_rd_en   <= (op != BTSK_OP_OTHER) && !nop_reg;          // [RULE3]
            o_rd_addr <= addr_bus.eff_addr;                 // [RULE4] [RULE5]
            o_indexed <= addr_bus.indexed;                            // [RULE6]
        end else begin
            o_rd_en   <= 1'b0;
        end
    end

    // Q2 read: capture the selected bit
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            bit_val_reg <= 1'b0;
        end else if (phase_reg == BTSK_Q2) begin
            bit_val_reg <= i_rd_data[bit_idx];                        // [RULE7]
        end
    end

    // Q3 process: skip decision, no write-back in Q4
    always_comb begin
        skip_cond = 1'b0;
        if (!nop_reg) begin
            if (op == BTSK_OP_SKIP_SET) begin
                skip_cond = bit_val_reg;                              // [RULE1]
            end else if (op == BTSK_OP_SKIP_CLEAR) begin
                skip_cond = !bit_val_reg;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_skip_taken <= 1'b0;
        end else begin
            o_skip_taken <= (phase_reg == BTSK_Q3) && skip_cond;      // [RULE1]
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_test_q3(btsk_op_e k, logic b);
        phase_reg == BTSK_Q3 && op == k && !nop_reg && bit_val_reg == b;
    endsequence

    sequence s_nop_cycle;
        o_discard [*4] ##1 !o_discard;
    endsequence

    sequence s_decode_q1;
        phase_reg == BTSK_Q1 && op != BTSK_OP_OTHER && !nop_reg;
    endsequence

    a_set_bit_skips: assert property ( // [RULE1]
        s_test_q3(BTSK_OP_SKIP_SET, 1'b1) |=> o_skip_taken)
        else $error("skip-if-set did not skip on a set bit");

    a_clear_bit_skips: assert property ( // [RULE7]
        s_test_q3(BTSK_OP_SKIP_CLEAR, 1'b0) |=> o_skip_taken)
        else $error("skip-if-clear did not skip on a clear bit");

    a_skip_has_cause: assert property ( // [RULE1]
        o_skip_taken |-> $past(phase_reg) == BTSK_Q3 && $past(skip_cond))
        else $error("skip taken without a matching bit test");

    a_discard_follows: assert property ( // [RULE2]
        o_skip_taken |=> s_nop_cycle)
        else $error("fetched word not discarded for one full cycle");

    a_nop_no_read: assert property ( // [RULE3]
        o_discard |-> !o_rd_en ##1 !o_skip_taken)
        else $error("discarded cycle read memory or skipped");

    a_quick_bank: assert property ( // [RULE4]
        s_decode_q1 and (!addr_bus.access && !addr_bus.indexed) |=>
        o_rd_addr[`BTSK_ADDR_W-1:8] == (o_rd_addr[7:0] < `BTSK_ACC_SPLIT ?
            `BTSK_ACC_LO_PAGE : `BTSK_ACC_HI_PAGE) && o_rd_en)
        else $error("access bank address wrong");

    a_bank_select: assert property ( // [RULE5]
        s_decode_q1 and (addr_bus.access) |=>
        o_rd_addr == {$past(i_bank_select), $past(addr_bus.f_addr)})
        else $error("banked address ignores bank select");

    a_indexed_mode: assert property ( // [RULE6]
        s_decode_q1 and (!addr_bus.access && i_ext_set_en &&
        addr_bus.f_addr <= `BTSK_IDX_LIMIT) |=> o_indexed &&
        o_rd_addr == $past(i_index_base) + {4'h0, $past(addr_bus.f_addr)})
        else $error("indexed literal offset address wrong");

endmodule : btsk_exec
`default_nettype wire

// File: pkg/btsk_cfg.svh
// constants for the bit-test-and-skip execution block
`ifndef BTSK_CFG_SVH
`define BTSK_CFG_SVH
`define BTSK_INSTR_W      16
`define BTSK_ADDR_W       12
`define BTSK_OPC_HI       15
`define BTSK_OPC_LO       12
`define BTSK_BIT_HI       11
`define BTSK_BIT_LO       9
`define BTSK_ACCESS_POS   8
`define BTSK_F_HI         7
`define BTSK_F_LO         0
`define BTSK_OPC_SKIP_CLR 4'hB
`define BTSK_OPC_SKIP_SET 4'hA
`define BTSK_IDX_LIMIT    8'h5F
`define BTSK_ACC_SPLIT    8'h60
`define BTSK_ACC_LO_PAGE  4'h0
`define BTSK_ACC_HI_PAGE  4'hF
`define BTSK_NOP_WORD     16'h0000
`define BTSK_Q_PER_CYCLE  4
`endif

// File: pkg/btsk_pkg.sv
// types for the bit-test-and-skip execution block
package btsk_pkg;
    typedef enum logic [1:0] {
        BTSK_Q1,
        BTSK_Q2,
        BTSK_Q3,
        BTSK_Q4
    } btsk_phase_e;

    typedef enum logic [1:0] {
        BTSK_OP_OTHER,
        BTSK_OP_SKIP_CLEAR,
        BTSK_OP_SKIP_SET
    } btsk_op_e;
endpackage : btsk_pkg

// File: pkg/btsk_addr_if.sv
// operand address request between sequencer and address generator
`timescale 1ns/1ps
`default_nettype none
`include "btsk_cfg.svh"
interface btsk_addr_if;
    logic [7:0]               f_addr;
    logic                     access;
    logic [3:0]               bank;
    logic                     ext_en;
    logic [`BTSK_ADDR_W-1:0]  index_base;
    logic [`BTSK_ADDR_W-1:0]  eff_addr;
    logic                     indexed;

    modport requester (
        output f_addr, access, bank, ext_en, index_base,
        input  eff_addr, indexed
    );
    modport generator (
        input  f_addr, access, bank, ext_en, index_base,
        output eff_addr, indexed
    );
endinterface : btsk_addr_if
`default_nettype wire

// File: hw/btsk_addr_gen.sv
// operand address generator: access bank, banked and indexed modes
`timescale 1ns/1ps
`default_nettype none
`include "btsk_cfg.svh"
module btsk_addr_gen (
    btsk_addr_if.generator a
);
    always_comb begin
        a.indexed  = 1'b0;
        a.eff_addr = {a.bank, a.f_addr};                 // [RULE5]
        if (!a.access) begin
            if (a.ext_en && (a.f_addr <= `BTSK_IDX_LIMIT)) begin
                a.indexed  = 1'b1;                       // [RULE6]
                a.eff_addr = a.index_base + {4'h0, a.f_addr};
            end else if (a.f_addr < `BTSK_ACC_SPLIT) begin
                a.eff_addr = {`BTSK_ACC_LO_PAGE, a.f_addr};  // [RULE4]
            end else begin
                a.eff_addr = {`BTSK_ACC_HI_PAGE, a.f_addr};  // [RULE4]
            end
        end
    end
endmodule : btsk_addr_gen
`default_nettype wire

// File: verification/test_bit_test_skip_exec.sv
// self-checking bench for the bit-test-and-skip execution block
`timescale 1ns/1ps
`default_nettype none
`include "btsk_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_bit_test_skip_exec;
    import btsk_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [15:0] i_instr = 16'h0000;
    logic [3:0]  i_bank_select = 4'h0;
    logic        i_ext_set_en = 1'b0;
    logic [11:0] i_index_base = 12'h000;
    logic [7:0]  i_rd_data = 8'h00;
    logic        o_cycle_start, o_rd_en, o_indexed, o_bit_test;
    logic        o_skip_taken, o_discard;
    logic [11:0] o_rd_addr;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    btsk_exec uut (
        .i_sys_clk     (i_sys_clk),
        .i_reset       (i_reset),
        .i_instr       (i_instr),
        .i_bank_select (i_bank_select),
        .i_ext_set_en  (i_ext_set_en),
        .i_index_base  (i_index_base),
        .i_rd_data     (i_rd_data),
        .o_cycle_start (o_cycle_start),
        .o_rd_en       (o_rd_en),
        .o_rd_addr     (o_rd_addr),
        .o_indexed     (o_indexed),
        .o_bit_test    (o_bit_test),
        .o_skip_taken  (o_skip_taken),
        .o_discard     (o_discard)
    );
    always #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    function automatic logic [15:0] mk(input logic [3:0] op,
        input logic [2:0] b, input logic a, input logic [7:0] f);
        return {op, b, a, f};
    endfunction : mk
    // entered in the Q4 clock; loads w, runs one cycle, returns in Q4
    task automatic issue(input logic [15:0] w, input logic [7:0] d,
        input logic rd, input logic [11:0] addr, input logic idx,
        input logic skip, input logic disc);
        i_instr = w;
        @(posedge i_sys_clk); #1;
        `CHK(o_cycle_start, 1'b1)
        `CHK(o_discard, disc)
        @(posedge i_sys_clk); #1;
        `CHK(o_rd_en, rd)
        `CHK(o_bit_test, rd)
        if (rd) begin
            `CHK(o_rd_addr, addr)
            `CHK(o_indexed, idx)
        end
        i_rd_data = d;
        @(posedge i_sys_clk); #1;
        @(posedge i_sys_clk); #1;
        `CHK(o_skip_taken, skip)
        `CHK(o_discard, disc)
        i_rd_data = ~d;
    endtask : issue
    // taken skip-if-set: next word discarded, then normal flow resumes
    task automatic t_skip_set();
        i_bank_select = 4'h5;
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd3, 1'b1, 8'h34), 8'h08,
              1'b1, 12'h534, 1'b0, 1'b1, 1'b0);
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd3, 1'b1, 8'h34), 8'h08,
              1'b0, 12'h000, 1'b0, 1'b0, 1'b1);
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd0, 1'b1, 8'hC1), 8'hFE,
              1'b1, 12'h5C1, 1'b0, 1'b0, 1'b0);
    endtask : t_skip_set
    // every bit index, both opcodes, only the tested bit matters
    task automatic t_bit_index();
        logic [7:0] d;
        i_bank_select = 4'h2;
        for (int b = 0; b < 8; b++) begin
            d = 8'hFF ^ (8'h01 << b);
            issue(mk(`BTSK_OPC_SKIP_SET, b[2:0], 1'b1, 8'h10), d,
                  1'b1, 12'h210, 1'b0, 1'b0, 1'b0);
            issue(mk(`BTSK_OPC_SKIP_CLR, b[2:0], 1'b1, 8'h11), d,
                  1'b1, 12'h211, 1'b0, 1'b1, 1'b0);
            issue(16'h0000, 8'h00, 1'b0, 12'h000, 1'b0, 1'b0,
                  1'b1);
            issue(mk(`BTSK_OPC_SKIP_CLR, b[2:0], 1'b1, 8'h12), ~d,
                  1'b1, 12'h212, 1'b0, 1'b0, 1'b0);
        end
    endtask : t_bit_index
    // access flag zero ignores the bank select, split at 60h
    task automatic t_access_bank();
        i_bank_select = 4'hA;
        i_ext_set_en = 1'b0;
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd1, 1'b0, 8'h5F), 8'h00,
              1'b1, 12'h05F, 1'b0, 1'b0, 1'b0);
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd1, 1'b0, 8'h60), 8'h00,
              1'b1, 12'hF60, 1'b0, 1'b0, 1'b0);
    endtask : t_access_bank
    // extended set: indexed offset up to 5Fh only, with wrap
    task automatic t_indexed();
        i_ext_set_en = 1'b1;
        i_index_base = 12'hFF0;
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd7, 1'b0, 8'h5F), 8'h80,
              1'b1, 12'h04F, 1'b1, 1'b1, 1'b0);
        issue(16'h0000, 8'h00, 1'b0, 12'h000, 1'b0, 1'b0, 1'b1);
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd7, 1'b0, 8'h60), 8'h00,
              1'b1, 12'hF60, 1'b0, 1'b0, 1'b0);
        issue(mk(`BTSK_OPC_SKIP_SET, 3'd7, 1'b1, 8'h05), 8'h00,
              1'b1, 12'hA05, 1'b0, 1'b0, 1'b0);
        i_ext_set_en = 1'b0;
    endtask : t_indexed
    // other opcodes neither read nor skip
    task automatic t_other_op();
        issue(mk(4'h9, 3'd0, 1'b1, 8'h01), 8'hFF,
              1'b0, 12'h000, 1'b0, 1'b0, 1'b0);
        issue(mk(4'hC, 3'd0, 1'b1, 8'h01), 8'h00,
              1'b0, 12'h000, 1'b0, 1'b0, 1'b0);
    endtask : t_other_op
    initial begin
        repeat (10) @(posedge i_sys_clk);
        #1;
        i_reset = 1'b0;
        t_skip_set();
        t_bit_index();
        t_access_bank();
        t_indexed();
        t_other_op();
        stop_test();
    end
endmodule : test_bit_test_skip_exec
`default_nettype wire
